// >>> hdl/tris_irq_status.sv
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - version register holds read-only five-bit version in bits 4:0, upper bits zero.
// - fifo error flag bit 7 sets on overflow/underflow, clears on fifo reset or, while enabled, on a status one read.
// - almost-full flag bit 6 sets when fifo count exceeds almost-full threshold.
// - almost-full clears itself during transmission once count is at or below threshold.
// - almost-empty flag bit 5 sets when untransmitted count is at or below threshold.
// - almost-empty clears itself once count rises above the almost-empty threshold.
// - external-event flag bit 3 sets on a gpio interrupt event.
// - packet-sent flag bit 2 sets on a completed, unaborted transmission.
// - packet-sent clears on leaving fifo mode or new transmission start in fifo mode.
// - an enabled bit of status one rising drives the interrupt pin low.
// - reading status one clears its enabled bits, bar any set in the read cycle; the pin releases once no enabled bit of either status is set.
// - non-enabled bits of status one are plain status, never read-cleared or interrupting.
// - wake-up flag bit 3 of status two sets on wake-up timer expiry.
// - low-battery flag bit 2 sets on event, kept while masked, interrupts once enabled.
// - module-ready flag bit 1 of status two sets on module-ready event.
// - power-on flag bit 0 of status two sets on detected power-on reset.
// - an enabled bit of status two rising drives the interrupt pin low.
// - reading status two clears its enabled bits, bar any set in the read cycle; the pin releases once no enabled bit of either status is set.
// - non-enabled bits of status two are plain status, unchanged by reads.
// - enable one bits 7,6,5,3,2 enable the same status one positions.
// - enable two bits 3..0 enable the same status two positions.
module tris_irq_status #(
  parameter int unsigned                   CNT_W   = 7,
  parameter int unsigned                   THR_W   = 6,
  parameter logic [tris_pkg::VER_W-1:0]    VERSION = tris_pkg::VERSION_DEF
) (
  input  wire logic                        mclk,
  input  wire logic                        sys_rst,
  input  wire logic [tris_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic                        reg_rd,
  input  wire logic                        reg_wr,
  input  wire logic [tris_pkg::DATA_W-1:0] reg_wdata,
  output var  logic [tris_pkg::DATA_W-1:0] reg_rdata,
  input  wire logic                        fifo_overflow,
  input  wire logic                        fifo_underflow,
  input  wire logic                        fifo_reset,
  input  wire logic                        fifo_ovfl_stat,
  input  wire logic                        fifo_unfl_stat,
  input  wire logic [CNT_W-1:0]            fifo_count,
  input  wire logic [THR_W-1:0]            afull_thr,
  input  wire logic [THR_W-1:0]            aempty_thr,
  input  wire logic                        tx_active,
  input  wire logic                        tx_start,
  input  wire logic                        fifo_mode,
  input  wire logic                        pkt_done,
  input  wire logic                        tx_abort,
  input  wire logic                        gpio_event,
  input  wire logic                        wut_expire,
  input  wire logic                        lbd_event,
  input  wire logic                        chip_ready_event,
  input  wire logic                        por_event,
  input  wire logic [tris_pkg::CPS_W-1:0]  power_state,
  output logic                             interrupt_pin_n
);
  import tris_pkg::*;

  logic [DATA_W-1:0] flags1_reg;
  logic [DATA_W-1:0] flags1_next;
  logic [DATA_W-1:0] flags2_reg;
  logic [DATA_W-1:0] flags2_next;
  logic [DATA_W-1:0] en1_reg;
  logic [DATA_W-1:0] en2_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic [DATA_W-1:0] set1;
  logic [DATA_W-1:0] clr1;
  logic [DATA_W-1:0] set2;
  logic [DATA_W-1:0] clr2;
  logic              afull_cond;
  logic              aempty_cond;
  logic              afull_cond_reg;
  logic              aempty_cond_reg;
  logic              fifo_mode_reg;
  logic              irq_reg;
  logic              pend;
  logic              rd_f1;
  logic              rd_f2;

  // thresholds widened to the count width; a 64-byte fifo needs one extra bit
  assign afull_cond  = fifo_count > {{(CNT_W-THR_W){1'b0}}, afull_thr};
  assign aempty_cond = fifo_count <= {{(CNT_W-THR_W){1'b0}}, aempty_thr};
  assign rd_f1       = reg_hit(reg_addr, ADDR_FLAGS1, reg_rd);
  assign rd_f2       = reg_hit(reg_addr, ADDR_FLAGS2, reg_rd);

  // conditions are edge-triggered so a read-clear does not re-fire at once
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      afull_cond_reg  <= 1'b0;
      aempty_cond_reg <= 1'b0;
      fifo_mode_reg   <= 1'b0;
    end
    else
    begin
      afull_cond_reg  <= afull_cond;
      aempty_cond_reg <= aempty_cond;
      fifo_mode_reg   <= fifo_mode;
    end
  end

  always_comb
  begin
    set1 = 8'h00;
    clr1 = 8'h00;
    set1[BIT_FFERR]  = fifo_overflow | fifo_underflow;
    clr1[BIT_FFERR]  = fifo_reset;
    set1[BIT_AFULL]  = afull_cond & ~afull_cond_reg;
    clr1[BIT_AFULL]  = tx_active & ~afull_cond;
    set1[BIT_AEMPTY] = aempty_cond & ~aempty_cond_reg;
    clr1[BIT_AEMPTY] = ~aempty_cond;
    set1[BIT_EXT]    = gpio_event;
    set1[BIT_PKSENT] = pkt_done & ~tx_abort;
    clr1[BIT_PKSENT] = (fifo_mode_reg & ~fifo_mode) | (tx_start & fifo_mode);
    if (rd_f1)
    begin
      clr1 = clr1 | en1_reg;
    end
    // a set in the clearing cycle wins
    flags1_next = ((flags1_reg & ~clr1) | set1) & FLAGS1_MASK;
  end

  always_comb
  begin
    set2 = 8'h00;
    clr2 = 8'h00;
    set2[BIT_WUT] = wut_expire;
    set2[BIT_LBD] = lbd_event;
    set2[BIT_RDY] = chip_ready_event;
    set2[BIT_POR] = por_event;
    if (rd_f2)
    begin
      clr2 = en2_reg;
    end
    flags2_next = ((flags2_reg & ~clr2) | set2) & FLAGS2_MASK;
  end

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      flags1_reg <= FLAGS_RST;
      flags2_reg <= FLAGS_RST;
    end
    else
    begin
      flags1_reg <= flags1_next;
      flags2_reg <= flags2_next;
    end
  end

  // reserved enable bits are not stored and read as zero
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      en1_reg <= EN1_RST;
      en2_reg <= EN2_RST;
    end
    else
    begin
      if (reg_hit(reg_addr, ADDR_EN1, reg_wr))
      begin
        en1_reg <= reg_wdata & FLAGS1_MASK;
      end
      if (reg_hit(reg_addr, ADDR_EN2, reg_wr))
      begin
        en2_reg <= reg_wdata & FLAGS2_MASK;
      end
    end
  end

  always_comb
  begin
    rdata_next = 8'h00;
    unique case (reg_addr)
      ADDR_VERSION: rdata_next = {{(DATA_W-VER_W){1'b0}}, VERSION};
      ADDR_STATE:   rdata_next = {fifo_ovfl_stat, fifo_unfl_stat, 4'h0, power_state};
      ADDR_FLAGS1:  rdata_next = flags1_reg;
      ADDR_FLAGS2:  rdata_next = flags2_reg;
      ADDR_EN1:     rdata_next = en1_reg;
      ADDR_EN2:     rdata_next = en2_reg;
      default:      rdata_next = 8'h00;
    endcase
  end

  // read data holds until the next read
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rdata_reg <= RDATA_RST;
    end
    else if (reg_rd)
    begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

  // level on pending bits: a masked event interrupts once enabled
  assign pend = (|(flags1_reg & en1_reg)) | (|(flags2_reg & en2_reg));

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      irq_reg <= 1'b0;
    end
    else
    begin
      irq_reg <= pend;
    end
  end

  assign interrupt_pin_n = ~irq_reg;

  property p_version;
    @(posedge mclk) disable iff (sys_rst)
    reg_rd && (reg_addr == ADDR_VERSION) |=> reg_rdata == {3'b000, VERSION};
  endproperty
  a_version: assert property (p_version) else $error("version read wrong");

  property p_fferr_hold;
    @(posedge mclk) disable iff (sys_rst)
    flags1_reg[BIT_FFERR] && !fifo_reset && !(rd_f1 && en1_reg[BIT_FFERR])
      |=> flags1_reg[BIT_FFERR];
  endproperty
  a_fferr_hold: assert property (p_fferr_hold) else $error("fifo error flag lost");

  property p_fferr_set;
    @(posedge mclk) disable iff (sys_rst)
    fifo_overflow || fifo_underflow |=> flags1_reg[BIT_FFERR];
  endproperty
  a_fferr_set: assert property (p_fferr_set) else $error("fifo error flag not set");

  property p_afull_set;
    @(posedge mclk) disable iff (sys_rst)
    afull_cond && !afull_cond_reg |=> flags1_reg[BIT_AFULL];
  endproperty
  a_afull_set: assert property (p_afull_set) else $error("almost full not set");

  property p_afull_clr;
    @(posedge mclk) disable iff (sys_rst)
    tx_active && !afull_cond |=> !flags1_reg[BIT_AFULL];
  endproperty
  a_afull_clr: assert property (p_afull_clr) else $error("almost full not cleared");

  property p_aempty_clr;
    @(posedge mclk) disable iff (sys_rst)
    !aempty_cond |=> !flags1_reg[BIT_AEMPTY];
  endproperty
  a_aempty_clr: assert property (p_aempty_clr) else $error("almost empty not cleared");

  property p_aempty_set;
    @(posedge mclk) disable iff (sys_rst)
    aempty_cond && !aempty_cond_reg |=> flags1_reg[BIT_AEMPTY];
  endproperty
  a_aempty_set: assert property (p_aempty_set) else $error("almost empty not set");

  property p_ext_set;
    @(posedge mclk) disable iff (sys_rst)
    gpio_event |=> flags1_reg[BIT_EXT];
  endproperty
  a_ext_set: assert property (p_ext_set) else $error("external flag not set");

  property p_pksent_set;
    @(posedge mclk) disable iff (sys_rst)
    pkt_done && !tx_abort |=> flags1_reg[BIT_PKSENT];
  endproperty
  a_pksent_set: assert property (p_pksent_set) else $error("packet sent not set");

  property p_pksent_clr;
    @(posedge mclk) disable iff (sys_rst)
    $fell(fifo_mode) && !(pkt_done && !tx_abort) |=> !flags1_reg[BIT_PKSENT];
  endproperty
  a_pksent_clr: assert property (p_pksent_clr) else $error("packet sent not cleared");

  property p_irq_low;
    @(posedge mclk) disable iff (sys_rst)
    $rose(|(flags1_reg & en1_reg)) |=> !interrupt_pin_n;
  endproperty
  a_irq_low: assert property (p_irq_low) else $error("pin not low on enabled event");

  property p_rd_clear1;
    @(posedge mclk) disable iff (sys_rst)
    rd_f1 && (set1 == 8'h00) |=> (flags1_reg & $past(en1_reg)) == 8'h00;
  endproperty
  a_rd_clear1: assert property (p_rd_clear1) else $error("enabled bits not read-cleared");

  // only checked when no event lands in the read cycle, since set wins
  property p_rd_clear2;
    @(posedge mclk) disable iff (sys_rst)
    rd_f2 && (set2 == 8'h00) |=> (flags2_reg & $past(en2_reg)) == 8'h00;
  endproperty
  a_rd_clear2: assert property (p_rd_clear2) else $error("status two not read-cleared");

  property p_wut_set;
    @(posedge mclk) disable iff (sys_rst)
    wut_expire |=> flags2_reg[BIT_WUT];
  endproperty
  a_wut_set: assert property (p_wut_set) else $error("wake-up flag not set");

  property p_lbd_kept;
    @(posedge mclk) disable iff (sys_rst)
    flags2_reg[BIT_LBD] && !en2_reg[BIT_LBD] ##1 en2_reg[BIT_LBD] |=> !interrupt_pin_n;
  endproperty
  a_lbd_kept: assert property (p_lbd_kept) else $error("masked low battery lost");

  property p_plain2;
    @(posedge mclk) disable iff (sys_rst)
    rd_f2 |=> ((flags2_reg ^ $past(flags2_reg)) & ~$past(en2_reg)) == 8'h00;
  endproperty
  a_plain2: assert property (p_plain2) else $error("plain status bit changed by read");

  property p_en1_write;
    @(posedge mclk) disable iff (sys_rst)
    reg_hit(reg_addr, ADDR_EN1, reg_wr) |=> en1_reg == ($past(reg_wdata) & FLAGS1_MASK);
  endproperty
  a_en1_write: assert property (p_en1_write) else $error("enable one not written");

  property p_release;
    @(posedge mclk) disable iff (sys_rst)
    !pend [*2] |-> interrupt_pin_n;
  endproperty
  a_release: assert property (p_release) else $error("pin low with nothing pending");

  property p_irq2_low;
    @(posedge mclk) disable iff (sys_rst)
    $rose(|(flags2_reg & en2_reg)) |=> !interrupt_pin_n;
  endproperty
  a_irq2_low: assert property (p_irq2_low) else $error("pin not low on status two event");

  c_service1: cover property (@(posedge mclk) disable iff (sys_rst)
    !interrupt_pin_n ##1 rd_f1 ##2 interrupt_pin_n);
  c_lbd_late: cover property (@(posedge mclk) disable iff (sys_rst)
    lbd_event && !en2_reg[BIT_LBD] ##[1:20] en2_reg[BIT_LBD]);
  c_both_pending: cover property (@(posedge mclk) disable iff (sys_rst)
    (|(flags1_reg & en1_reg)) && (|(flags2_reg & en2_reg)));
  c_set_on_clear: cover property (@(posedge mclk) disable iff (sys_rst)
    rd_f1 && set1[BIT_EXT] && en1_reg[BIT_EXT]);
endmodule
`default_nettype wire

// >>> hdl/tris_pkg.sv
`default_nettype none
package tris_pkg;
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned DATA_W = 8;

  localparam logic [ADDR_W-1:0] ADDR_VERSION = 7'h01;
  localparam logic [ADDR_W-1:0] ADDR_STATE   = 7'h02;
  localparam logic [ADDR_W-1:0] ADDR_FLAGS1  = 7'h03;
  localparam logic [ADDR_W-1:0] ADDR_FLAGS2  = 7'h04;
  localparam logic [ADDR_W-1:0] ADDR_EN1     = 7'h05;
  localparam logic [ADDR_W-1:0] ADDR_EN2     = 7'h06;

  localparam int unsigned BIT_FFERR  = 7;
  localparam int unsigned BIT_AFULL  = 6;
  localparam int unsigned BIT_AEMPTY = 5;
  localparam int unsigned BIT_EXT    = 3;
  localparam int unsigned BIT_PKSENT = 2;
  localparam int unsigned BIT_WUT    = 3;
  localparam int unsigned BIT_LBD    = 2;
  localparam int unsigned BIT_RDY    = 1;
  localparam int unsigned BIT_POR    = 0;
  localparam int unsigned VER_W      = 5;
  localparam int unsigned BIT_OVFL   = 7;
  localparam int unsigned BIT_UNFL   = 6;
  localparam int unsigned CPS_W      = 2;

  localparam logic [DATA_W-1:0] FLAGS1_MASK = 8'hEC;
  localparam logic [DATA_W-1:0] FLAGS2_MASK = 8'h0F;
  localparam logic [DATA_W-1:0] FLAGS_RST   = 8'h00;
  localparam logic [DATA_W-1:0] EN1_RST     = 8'h00;
  localparam logic [DATA_W-1:0] EN2_RST     = 8'h00;
  localparam logic [DATA_W-1:0] RDATA_RST   = 8'h00;
  // arbitrary value, not a real part revision
  localparam logic [VER_W-1:0]  VERSION_DEF = 5'h1A;

  function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
                                   input logic [ADDR_W-1:0] t,
                                   input logic              stb);
    reg_hit = stb && (a == t);
  endfunction
endpackage
`default_nettype wire

// >>> tb/tris_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module tris_host_model (
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  input  wire logic       interrupt_pin_n,
  output var  logic [7:0] irq_count
);
  logic pin_d_reg;

  // host sees each falling pin as one service request, answered by a flag read
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pin_d_reg <= 1'b1;
      irq_count <= 8'h00;
    end
    else
    begin
      pin_d_reg <= interrupt_pin_n;
      if (pin_d_reg && !interrupt_pin_n)
        irq_count <= irq_count + 8'h01;
    end
  end
endmodule
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import tris_pkg::*;
  logic       mclk, sys_rst, reg_rd, reg_wr, tx_active, fifo_mode, tx_abort, pin_n;
  logic [6:0] reg_addr, fifo_count;
  logic [7:0] reg_wdata, reg_rdata, irq_count;
  logic [5:0] afull_thr, aempty_thr;
  logic [9:0] ev;
  int         fails, tests_run;

  // status inputs tied: only shown in the state register, no flag logic behind them
  tris_irq_status i_dut (
    .mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .fifo_overflow(ev[5]), .fifo_underflow(ev[6]), .fifo_reset(ev[9]),
    .fifo_ovfl_stat(1'b0), .fifo_unfl_stat(1'b0), .fifo_count(fifo_count),
    .afull_thr(afull_thr), .aempty_thr(aempty_thr), .tx_active(tx_active),
    .tx_start(ev[8]), .fifo_mode(fifo_mode), .pkt_done(ev[7]), .tx_abort(tx_abort),
    .gpio_event(ev[4]), .wut_expire(ev[3]), .lbd_event(ev[2]),
    .chip_ready_event(ev[1]), .por_event(ev[0]), .power_state(2'b10),
    .interrupt_pin_n(pin_n)
  );

  tris_host_model i_host (
    .mclk(mclk), .sys_rst(sys_rst), .interrupt_pin_n(pin_n), .irq_count(irq_count)
  );

  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask

  // read data is registered, so it is compared one cycle after the strobe
  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    chk("reg_rdata", reg_rdata, exp);
  endtask

  task automatic pulse(input int k);
    @(negedge mclk);
    ev[k] = 1'b1;
    @(negedge mclk);
    ev = '0;
  endtask

  task automatic pin(input logic exp);
    chk("interrupt_pin_n", {7'h00, pin_n}, {7'h00, exp});
  endtask

  initial
  begin
    repeat (20000) @(posedge mclk);
    fails++;
    $display("CHECK FAILED run time limit expected 0 seen 1");
    end_of_test();
  end

  initial
  begin
    {reg_rd, reg_wr, tx_active, fifo_mode, tx_abort} = '0;
    reg_addr = 7'h00;
    reg_wdata = 8'h00;
    ev = '0;
    fifo_count = 7'h0A;
    afull_thr = 6'h28;
    aempty_thr = 6'h04;
    fails = 0;
    tests_run = 0;
    sys_rst = 1'b1;
    repeat (5) @(posedge mclk);
    @(negedge mclk);
    sys_rst = 1'b0;
    rd(ADDR_VERSION, {3'h0, VERSION_DEF});
    rd(ADDR_STATE, 8'h02);
    rd(ADDR_FLAGS1, 8'h00);
    rd(ADDR_FLAGS2, 8'h00);
    pin(1'b1);
    wr(ADDR_EN1, 8'hFF);
    rd(ADDR_EN1, 8'hEC);
    wr(ADDR_EN2, 8'hFF);
    rd(ADDR_EN2, 8'h0F);
    wr(ADDR_VERSION, 8'hFF);
    rd(ADDR_VERSION, {3'h0, VERSION_DEF});
    rd(7'h07, 8'h00);
    for (int k = 0; k < 4; k++)
    begin
      pulse(k);
      cyc(1);
      pin(1'b0);
      rd(ADDR_FLAGS2, 8'h01 << k);
      cyc(1);
      pin(1'b1);
    end
    pulse(4);
    cyc(1);
    pin(1'b0);
    rd(ADDR_FLAGS1, 8'h08);
    cyc(1);
    pin(1'b1);
    wr(ADDR_EN1, 8'h00);
    pulse(4);
    cyc(1);
    pin(1'b1);
    rd(ADDR_FLAGS1, 8'h08);
    rd(ADDR_FLAGS1, 8'h08);
    wr(ADDR_EN2, 8'h0B);
    pulse(2);
    cyc(1);
    pin(1'b1);
    rd(ADDR_FLAGS2, 8'h04);
    wr(ADDR_EN2, 8'h0F);
    cyc(1);
    pin(1'b0);
    rd(ADDR_FLAGS2, 8'h04);
    cyc(1);
    pin(1'b1);
    for (int k = 5; k < 7; k++)
    begin
      pulse(k);
      rd(ADDR_FLAGS1, 8'h88);
      rd(ADDR_FLAGS1, 8'h88);
      pulse(9);
      rd(ADDR_FLAGS1, 8'h08);
    end
    fifo_count = 7'h29;
    rd(ADDR_FLAGS1, 8'h48);
    tx_active = 1'b1;
    fifo_count = 7'h28;
    rd(ADDR_FLAGS1, 8'h08);
    fifo_count = 7'h04;
    rd(ADDR_FLAGS1, 8'h28);
    fifo_count = 7'h05;
    rd(ADDR_FLAGS1, 8'h08);
    tx_active = 1'b0;
    fifo_mode = 1'b1;
    pulse(7);
    rd(ADDR_FLAGS1, 8'h0C);
    pulse(8);
    rd(ADDR_FLAGS1, 8'h08);
    tx_abort = 1'b1;
    pulse(7);
    tx_abort = 1'b0;
    rd(ADDR_FLAGS1, 8'h08);
    pulse(7);
    rd(ADDR_FLAGS1, 8'h0C);
    fifo_mode = 1'b0;
    rd(ADDR_FLAGS1, 8'h08);
    wr(ADDR_EN1, 8'hEC);
    cyc(1);
    pin(1'b0);
    pulse(3);
    rd(ADDR_FLAGS1, 8'h08);
    cyc(1);
    pin(1'b0);
    rd(ADDR_FLAGS2, 8'h08);
    cyc(1);
    pin(1'b1);
    chk("irq_count", irq_count, 8'h07);
    // event in the very cycle of the read-clear must survive
    @(negedge mclk);
    reg_addr = ADDR_FLAGS1;
    reg_rd = 1'b1;
    ev[4] = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    ev = '0;
    chk("reg_rdata", reg_rdata, 8'h00);
    rd(ADDR_FLAGS1, 8'h08);
    cyc(1);
    pin(1'b1);
    chk("irq_count", irq_count, 8'h08);
    // reset in mid-run while the pin is low
    pulse(4);
    cyc(1);
    pin(1'b0);
    sys_rst = 1'b1;
    cyc(2);
    pin(1'b1);
    chk("reg_rdata", reg_rdata, 8'h00);
    sys_rst = 1'b0;
    rd(ADDR_FLAGS1, 8'h00);
    rd(ADDR_EN1, 8'h00);
    pin(1'b1);
    end_of_test();
  end
endmodule
`default_nettype wire
